// file: logic/a2pwm_defines.svh
`ifndef A2PWM_DEFINES_SVH
`define A2PWM_DEFINES_SVH

// Clock and timebase timing.
`define A2P_CLK_NS 8
`define A2P_MS_NS 1000000

// Timebase unit lengths in milliseconds, selected by the timebase field.
`define A2P_TB0_MS 16'h0001
`define A2P_TB1_MS 16'h000a
`define A2P_TB2_MS 16'h03e8
`define A2P_TB3_MS 16'hea60

// Parameter limits; gain is held in hundredths.
`define A2P_GAIN_MAX 32'sh0000_03e8
`define A2P_OFFS_MAX 32'sh0000_2710
`define A2P_BOUND_MAX 32'sh0000_4e20
`define A2P_DEC_MAX 2'h3
`define A2P_FRAC_SCALE 32'sh0000_0064

// Register byte offsets.
`define A2P_REG_GAIN 8'h00
`define A2P_REG_OFFS 8'h04
`define A2P_REG_LOWER 8'h08
`define A2P_REG_UPPER 8'h0c
`define A2P_REG_PERIOD 8'h10
`define A2P_REG_CFG 8'h14
`define A2P_REG_STATUS 8'h18
`define A2P_REG_SCALED 8'h1c

// Field positions.
`define A2P_CFG_SRC 0
`define A2P_CFG_TB_LO 1
`define A2P_CFG_TB_HI 2
`define A2P_CFG_DEC_LO 3
`define A2P_CFG_DEC_HI 4
`define A2P_ST_RUN 0
`define A2P_ST_OUT 1

// Reset values.
`define A2P_RST_GAIN 16'h0064
`define A2P_RST_OFFS 16'h0000
`define A2P_RST_LOWER 16'h0000
`define A2P_RST_UPPER 16'h03e8
`define A2P_RST_PERIOD 16'h0004
`define A2P_RST_TB 2'h2

`endif

// file: logic/a2pwm_pkg.sv
`default_nettype none
package a2pwm_pkg;

  // Software settings carried from the register file to the modulator.
  typedef struct packed {
    logic signed [15:0] gain;
    logic signed [15:0] offset;
    logic signed [15:0] lower;
    logic signed [15:0] upper;
    logic [15:0] period;
    logic period_src;
    logic [1:0] timebase;
    logic [1:0] decimals;
  } a2pwm_cfg_s;

  typedef enum logic {
    A2PWM_IDLE,
    A2PWM_RUN
  } a2pwm_state_e;

endpackage
`default_nettype wire

// file: logic/a2pwm_core.sv
`default_nettype none
`include "a2pwm_defines.svh"
module a2pwm_core #(
  parameter int VW = 16,
  parameter int PW = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic unit_tick_i,
  input wire logic signed [VW-1:0] analog_in_value_i,
  input wire a2pwm_pkg::a2pwm_cfg_s cfg_i,
  input wire logic [PW-1:0] period_i,
  output logic pwm_o,
  output logic running_o,
  output logic signed [31:0] scaled_x100_o
);
  a2pwm_pkg::a2pwm_state_e state, next_state;
  logic en_q, next_en_q, pwm, next_pwm, start, wrap;
  logic [PW-1:0] elapsed, next_elapsed, per_lat, next_per_lat;
  logic signed [31:0] s_lat, next_s_lat, lo_lat, next_lo_lat, hi_lat, next_hi_lat;
  logic signed [31:0] scaled_now;
  logic [47:0] lhs, rhs;

  // Work in hundredths so the fractional gain needs no divider.
  assign scaled_now = 32'(analog_in_value_i) * 32'(cfg_i.gain)
                    + 32'(cfg_i.offset) * `A2P_FRAC_SCALE;
  assign start = enable_i && !en_q;
  assign wrap = unit_tick_i && (elapsed >= PW'(per_lat - PW'(1)));
  // Cross-multiplied compare avoids a divide per cycle.
  assign lhs = 48'(elapsed) * 48'($unsigned(hi_lat - lo_lat));
  assign rhs = 48'($unsigned(s_lat - lo_lat)) * 48'(per_lat);

  // Next state, period position and the values latched once per period.
  always_comb begin
    next_en_q = enable_i;
    next_state = state;
    next_elapsed = elapsed;
    next_per_lat = per_lat;
    next_s_lat = s_lat;
    next_lo_lat = lo_lat;
    next_hi_lat = hi_lat;
    next_pwm = 1'b0;
    if (!enable_i) begin
      next_state = a2pwm_pkg::A2PWM_IDLE;
      next_elapsed = '0;
    end else if (start || (state == a2pwm_pkg::A2PWM_RUN && wrap)) begin
      next_state = a2pwm_pkg::A2PWM_RUN;
      next_elapsed = '0;
      next_per_lat = (period_i == '0) ? PW'(1) : period_i;
      next_s_lat = scaled_now;
      next_lo_lat = 32'(cfg_i.lower) * `A2P_FRAC_SCALE;
      next_hi_lat = 32'(cfg_i.upper) * `A2P_FRAC_SCALE;
    end else if (state == a2pwm_pkg::A2PWM_RUN && unit_tick_i) begin
      next_elapsed = PW'(elapsed + PW'(1));
    end
    case (state)
      a2pwm_pkg::A2PWM_RUN: begin
        if (!enable_i || s_lat <= lo_lat) begin
          next_pwm = 1'b0;
        end else if (s_lat >= hi_lat) begin
          next_pwm = 1'b1;
        end else begin
          next_pwm = lhs < rhs;
        end
      end
      default: begin
        next_pwm = 1'b0;
      end
    endcase
  end

  // Registers freeze whenever the clock enable is low.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= a2pwm_pkg::A2PWM_IDLE;
      en_q <= 1'b0;
      elapsed <= '0;
      per_lat <= PW'(1);
      s_lat <= '0;
      lo_lat <= '0;
      hi_lat <= '0;
      pwm <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      en_q <= next_en_q;
      elapsed <= next_elapsed;
      per_lat <= next_per_lat;
      s_lat <= next_s_lat;
      lo_lat <= next_lo_lat;
      hi_lat <= next_hi_lat;
      pwm <= next_pwm;
    end
  end

  assign pwm_o = pwm;
  assign running_o = (state == a2pwm_pkg::A2PWM_RUN);
  assign scaled_x100_o = s_lat;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_START: assert property (ce_i && start |=> running_o && elapsed == '0)
    else $error("Enable rise did not start a period.");
  AST_SCALE: assert property (ce_i && start |=> scaled_x100_o == $past(scaled_now))
    else $error("Scaled value not latched at start.");
  AST_OFF_LOW: assert property (ce_i && !enable_i |=> !pwm_o && !running_o)
    else $error("Output not low while disabled.");
  AST_FULL_LOW: assert property (ce_i && running_o && s_lat <= lo_lat |=> !pwm_o)
    else $error("Output high below lower bound.");
  AST_FULL_HIGH: assert property (ce_i && running_o && enable_i && s_lat >= hi_lat
    && s_lat > lo_lat |=> pwm_o)
    else $error("Output low above upper bound.");
  AST_PERIOD_HEAD: assert property (ce_i && running_o && enable_i && s_lat > lo_lat
    && s_lat < hi_lat && elapsed == '0 |=> pwm_o)
    else $error("In-range period did not begin high.");
  AST_WRAP: assert property (ce_i && running_o && enable_i && wrap |=> elapsed == '0
    && running_o)
    else $error("Period did not restart.");
  AST_POS: assert property (running_o |-> elapsed < per_lat)
    else $error("Period position beyond period.");
  COV_START: cover property (ce_i && start);
  COV_FALL: cover property (running_o && $fell(pwm_o));
  COV_WRAP: cover property (ce_i && running_o && wrap);
endmodule
`default_nettype wire

// file: logic/a2pwm_top.sv
`default_nettype none
`include "a2pwm_defines.svh"
module a2pwm_top #(
  parameter int VW = 16,
  parameter int MS_CYCLES = `A2P_MS_NS / `A2P_CLK_NS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic signed [VW-1:0] analog_in_value_i,
  input wire logic [15:0] ext_period_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  output logic pwm_o,
  output logic running_o
);
  localparam int MSW = $clog2(MS_CYCLES + 1);

  a2pwm_pkg::a2pwm_cfg_s cfg, next_cfg;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] hrdata, next_hrdata, rd_word;
  logic take;
  logic [7:0] rd_addr;
  logic [MSW-1:0] ms_cnt, next_ms_cnt;
  logic [15:0] unit_cnt, next_unit_cnt, unit_len;
  logic ms_tick, unit_tick;
  logic [15:0] period_eff;
  logic signed [31:0] scaled_x100;

  // Clamp a written value into a symmetric signed range.
  function automatic logic signed [15:0] sat_val(input logic signed [31:0] v,
                                                 input logic signed [31:0] lim);
    logic signed [31:0] r;
    r = v;
    if (v > lim) begin
      r = lim;
    end else if (v < -lim) begin
      r = -lim;
    end
    return r[15:0];
  endfunction

  // Length of one timebase unit in milliseconds.
  function automatic logic [15:0] unit_ms(input logic [1:0] sel);
    logic [15:0] r;
    case (sel)
      2'h0: r = `A2P_TB0_MS;
      2'h1: r = `A2P_TB1_MS;
      2'h2: r = `A2P_TB2_MS;
      default: r = `A2P_TB3_MS;
    endcase
    return r;
  endfunction

  assign take = hsel_i && htrans_i[1] && hready_i;
  assign rd_addr = {haddr_i[7:2], 2'h0};

  // Zero-wait slave: writes land in the data phase, reads are fetched at the
  // address phase. The read mux looks at the post-write settings so a read
  // right behind a write to the same register returns the new value.
  always_comb begin
    next_cfg = cfg;
    next_wr_pend = take && hwrite_i;
    next_wr_addr = take ? rd_addr : wr_addr;
    next_hrdata = hrdata;
    rd_word = '0;
    if (wr_pend) begin
      case (wr_addr)
        `A2P_REG_GAIN: next_cfg.gain = sat_val(hwdata_i, `A2P_GAIN_MAX);
        `A2P_REG_OFFS: next_cfg.offset = sat_val(hwdata_i, `A2P_OFFS_MAX);
        `A2P_REG_LOWER: next_cfg.lower = sat_val(hwdata_i, `A2P_BOUND_MAX);
        `A2P_REG_UPPER: next_cfg.upper = sat_val(hwdata_i, `A2P_BOUND_MAX);
        `A2P_REG_PERIOD: next_cfg.period = hwdata_i[15:0];
        `A2P_REG_CFG: begin
          next_cfg.period_src = hwdata_i[`A2P_CFG_SRC];
          next_cfg.timebase = hwdata_i[`A2P_CFG_TB_HI:`A2P_CFG_TB_LO];
          // Decimals are kept for display software only.
          next_cfg.decimals = hwdata_i[`A2P_CFG_DEC_HI:`A2P_CFG_DEC_LO];
        end
        default: begin
          next_cfg = cfg;
        end
      endcase
    end
    case (rd_addr)
      `A2P_REG_GAIN: rd_word = 32'(next_cfg.gain);
      `A2P_REG_OFFS: rd_word = 32'(next_cfg.offset);
      `A2P_REG_LOWER: rd_word = 32'(next_cfg.lower);
      `A2P_REG_UPPER: rd_word = 32'(next_cfg.upper);
      `A2P_REG_PERIOD: rd_word = 32'(next_cfg.period);
      `A2P_REG_CFG: begin
        rd_word[`A2P_CFG_SRC] = next_cfg.period_src;
        rd_word[`A2P_CFG_TB_HI:`A2P_CFG_TB_LO] = next_cfg.timebase;
        rd_word[`A2P_CFG_DEC_HI:`A2P_CFG_DEC_LO] = next_cfg.decimals;
      end
      `A2P_REG_STATUS: begin
        rd_word[`A2P_ST_RUN] = running_o;
        rd_word[`A2P_ST_OUT] = pwm_o;
      end
      `A2P_REG_SCALED: rd_word = scaled_x100;
      default: rd_word = '0;
    endcase
    if (take && !hwrite_i) begin
      next_hrdata = rd_word;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg.gain <= `A2P_RST_GAIN;
      cfg.offset <= `A2P_RST_OFFS;
      cfg.lower <= `A2P_RST_LOWER;
      cfg.upper <= `A2P_RST_UPPER;
      cfg.period <= `A2P_RST_PERIOD;
      cfg.period_src <= 1'b0;
      cfg.timebase <= `A2P_RST_TB;
      cfg.decimals <= 2'h0;
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= '0;
    end else if (ce_i) begin
      cfg <= next_cfg;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata;

  // Millisecond prescaler and timebase unit counter. Both are held at zero
  // until a run is under way, so the first unit after an enable rise is as
  // long as every later one and the first period is not cut short.
  assign unit_len = unit_ms(cfg.timebase);
  assign ms_tick = (ms_cnt == MSW'(MS_CYCLES - 1));
  assign unit_tick = ms_tick && (unit_cnt >= 16'(unit_len - 16'h0001));
  always_comb begin
    next_ms_cnt = ms_tick ? '0 : MSW'(ms_cnt + MSW'(1));
    next_unit_cnt = unit_cnt;
    if (ms_tick) begin
      next_unit_cnt = unit_tick ? '0 : 16'(unit_cnt + 16'h0001);
    end
    if (!enable_i || !running_o) begin
      next_ms_cnt = '0;
      next_unit_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt <= '0;
      unit_cnt <= '0;
    end else if (ce_i) begin
      ms_cnt <= next_ms_cnt;
      unit_cnt <= next_unit_cnt;
    end
  end

  // Period comes either from the stored constant or from a live source.
  assign period_eff = cfg.period_src ? ext_period_i : cfg.period;

  a2pwm_core #(
    .VW(VW),
    .PW(16)
  ) a2pwm_core_i (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .enable_i(enable_i),
    .unit_tick_i(unit_tick),
    .analog_in_value_i(analog_in_value_i),
    .cfg_i(cfg),
    .period_i(period_eff),
    .pwm_o(pwm_o),
    .running_o(running_o),
    .scaled_x100_o(scaled_x100)
  );

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_GAIN_LIM: assert property (32'(cfg.gain) <= `A2P_GAIN_MAX
    && 32'(cfg.gain) >= -`A2P_GAIN_MAX)
    else $error("Gain outside its range.");
  AST_GAIN_WR: assert property (ce_i && wr_pend && wr_addr == `A2P_REG_GAIN
    && $signed(hwdata_i) > `A2P_GAIN_MAX |=> 32'(cfg.gain) == `A2P_GAIN_MAX)
    else $error("Gain write not saturated.");
  AST_OFFS_LIM: assert property (32'(cfg.offset) <= `A2P_OFFS_MAX
    && 32'(cfg.offset) >= -`A2P_OFFS_MAX)
    else $error("Offset outside its range.");
  AST_BOUND_LIM: assert property (32'(cfg.lower) >= -`A2P_BOUND_MAX
    && 32'(cfg.upper) <= `A2P_BOUND_MAX)
    else $error("Range bound outside its range.");
  AST_DEC_WR: assert property (ce_i && wr_pend && wr_addr == `A2P_REG_CFG
    |=> cfg.decimals == $past(hwdata_i[`A2P_CFG_DEC_HI:`A2P_CFG_DEC_LO]))
    else $error("Decimals write not stored.");
  AST_UNIT: assert property (ce_i && enable_i && unit_tick |=> unit_cnt == '0
    && ms_cnt == '0)
    else $error("Timebase unit did not restart.");
  COV_EXT: cover property (cfg.period_src && running_o);
  COV_WRITE: cover property (ce_i && wr_pend && wr_addr == `A2P_REG_CFG);
endmodule
`default_nettype wire

// file: tb/a2pwm_far_model.sv
`default_nettype none
// Far side of the modulator: a registered analog value source and a pulse consumer.
module a2pwm_far_model #(
  parameter int VW = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic signed [VW-1:0] value_i,
  input wire logic pwm_i,
  input wire logic clr_i,
  output logic signed [VW-1:0] analog_in_value_o,
  output logic [31:0] high_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // The value moves one clock late, as a registered source block would present it.
  // The consumer counts high cycles, so any window of whole periods gives an exact figure.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_in_value_o <= '0;
      high_cnt_o <= 32'h0000_0000;
    end else begin
      analog_in_value_o <= value_i;
      high_cnt_o <= clr_i ? 32'h0000_0000 : high_cnt_o + {31'h0000_0000, pwm_i};
    end
  end
endmodule
`default_nettype wire

// file: tb/a2pwm_top_tb.sv
`default_nettype none
`include "a2pwm_defines.svh"
module a2pwm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, rst_n_i, ce_i, enable_i, hsel_i, hwrite_i, clr, hreadyout, hresp, pwm, running;
  logic signed [15:0] value, analog;
  logic [15:0] ext_period_i;
  logic [31:0] haddr_i, hwdata_i, hrdata, high_cnt;
  logic [1:0] htrans_i;
  int n_fail = 0;
  int num_checks = 0;

  // A short millisecond keeps one timebase-0 unit at four clocks.
  a2pwm_top #(.VW(16), .MS_CYCLES(4)) a2pwm_top_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .enable_i(enable_i),
    .analog_in_value_i(analog), .ext_period_i(ext_period_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .hrdata_o(hrdata), .pwm_o(pwm), .running_o(running));

  a2pwm_far_model #(.VW(16)) a2pwm_far_model_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .value_i(value), .pwm_i(pwm),
    .clr_i(clr), .analog_in_value_o(analog), .high_cnt_o(high_cnt));

  // Free-running 125 MHz clock.
  always #4 ref_clk_i = ~ref_clk_i;

  task automatic end_sim();
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; the request is held until hready is seen high.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge ref_clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h00_0000, a};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, a, {{16{d[15]}}, d}, x);
  endtask

  // Only the low half is compared, since sign extension of the upper half is not promised.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk({16'h0000, x[15:0]}, {16'h0000, exp});
  endtask

  task automatic setup(input logic [15:0] g, o, lo, up, per, input logic [15:0] cfg);
    wr(`A2P_REG_GAIN, g);
    wr(`A2P_REG_OFFS, o);
    wr(`A2P_REG_LOWER, lo);
    wr(`A2P_REG_UPPER, up);
    wr(`A2P_REG_PERIOD, per);
    wr(`A2P_REG_CFG, cfg);
  endtask

  // Starts a run, counts high cycles over a whole-period window, reads the scaled value.
  task automatic run(input logic [15:0] ax, input int win, input logic [31:0] exp,
                     output logic [31:0] s);
    @(posedge ref_clk_i);
    value <= ax;
    repeat (2) @(posedge ref_clk_i);
    #1 chk({31'h0, running}, 32'h0);
    @(posedge ref_clk_i);
    enable_i <= 1'b1;
    @(posedge ref_clk_i);
    #1 chk({31'h0, running}, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    clr <= 1'b1;
    @(posedge ref_clk_i);
    clr <= 1'b0;
    repeat (win) @(posedge ref_clk_i);
    #1 chk(high_cnt, exp);
    bus(1'b0, `A2P_REG_SCALED, 32'h0000_0000, s);
    enable_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 chk({30'h0, running, pwm}, 32'h0);
  endtask

  task automatic t_reset();
    rd_chk(`A2P_REG_GAIN, `A2P_RST_GAIN);
    rd_chk(`A2P_REG_OFFS, `A2P_RST_OFFS);
    rd_chk(`A2P_REG_LOWER, `A2P_RST_LOWER);
    rd_chk(`A2P_REG_UPPER, `A2P_RST_UPPER);
    rd_chk(`A2P_REG_PERIOD, `A2P_RST_PERIOD);
    rd_chk(`A2P_REG_CFG, 16'h0004);
    rd_chk(`A2P_REG_STATUS, 16'h0000);
    wr(8'h40, 16'hffff);
    rd_chk(8'h40, 16'h0000);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Out-of-range settings saturate at the documented limits.
  task automatic t_clamp();
    wr(`A2P_REG_GAIN, 16'h07d0);
    rd_chk(`A2P_REG_GAIN, 16'h03e8);
    wr(`A2P_REG_GAIN, 16'hf830);
    rd_chk(`A2P_REG_GAIN, 16'hfc18);
    wr(`A2P_REG_OFFS, 16'h4e20);
    rd_chk(`A2P_REG_OFFS, 16'h2710);
    wr(`A2P_REG_LOWER, 16'h8ad0);
    rd_chk(`A2P_REG_LOWER, 16'hb1e0);
    wr(`A2P_REG_UPPER, 16'h7530);
    rd_chk(`A2P_REG_UPPER, 16'h4e20);
  endtask

  task automatic t_duty();
    logic [31:0] s;
    setup(16'h0064, 16'h0000, 16'h0000, 16'h03e8, 16'h0004, 16'h0000);
    run(16'd500, 64, 32'd32, s);
    chk(s, 32'h0000_c350);
    wr(`A2P_REG_PERIOD, 16'h000a);
    run(16'd300, 80, 32'd24, s);
    setup(16'h00c8, 16'h0064, 16'h0000, 16'h03e8, 16'h000a, 16'h0018);
    run(16'd100, 80, 32'd24, s);
    chk(s, 32'h0000_7530);
    // A negative input cancels the offset, leaving the value mid-way from -1000 to 1000.
    wr(`A2P_REG_LOWER, 16'hfc18);
    run(16'hffce, 80, 32'd40, s);
    chk(s, 32'h0000_0000);
  endtask

  task automatic t_limits();
    logic [31:0] s;
    setup(16'h0064, 16'h0000, 16'h0000, 16'h03e8, 16'h000a, 16'h0000);
    run(16'd0, 80, 32'd0, s);
    run(16'hfffb, 80, 32'd0, s);
    run(16'd1000, 80, 32'd80, s);
  endtask

  // The live period of two units overrides the stored ten; then a stored two
  // runs on the timebase whose unit is ten times longer.
  task automatic t_ext();
    logic [31:0] s;
    wr(`A2P_REG_CFG, 16'h0001);
    ext_period_i <= 16'h0002;
    run(16'd500, 64, 32'd32, s);
    wr(`A2P_REG_PERIOD, 16'h0002);
    wr(`A2P_REG_CFG, 16'h0002);
    run(16'd500, 160, 32'd80, s);
  endtask

  // A low clock enable freezes the edge detector, so the rise only counts once it returns.
  task automatic t_ce();
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    enable_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 chk({31'h0, running}, 32'h0);
    @(posedge ref_clk_i);
    ce_i <= 1'b1;
    @(posedge ref_clk_i);
    #1 chk({31'h0, running}, 32'h1);
    @(posedge ref_clk_i);
    enable_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 chk({31'h0, running}, 32'h0);
  endtask

  initial begin
    ref_clk_i = 1'b0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    enable_i = 1'b0;
    hsel_i = 1'b0;
    hwrite_i = 1'b0;
    clr = 1'b0;
    value = 16'h0000;
    ext_period_i = 16'h0004;
    haddr_i = 32'h0000_0000;
    hwdata_i = 32'h0000_0000;
    htrans_i = 2'h0;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_clamp();
    t_duty();
    t_limits();
    t_ext();
    t_ce();
    end_sim();
  end

  // The whole run needs about a thousand clocks; this limit only catches a hang.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
